// *** dmact_mem_model.sv ***
// Memory slaves on both transfer controller ports.
// Same clock as the design; a taken read word is a pure function of the address.
`timescale 1ns/1ps
module dmact_mem_model
  import dmact_pkg::*;
(
  // Clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  // Ports
  input wire logic [NQ-1:0] rd_i,
  input wire logic [NQ-1:0][31:0] rd_addr_i,
  output logic [NQ-1:0] rd_wait_o,
  output logic [NQ-1:0][31:0] rd_data_o,
  output logic [NQ-1:0] wr_wait_o
);
  logic [1:0] tick_ff;
  always_ff @(posedge clk_i) begin
    tick_ff <= rst_i ? 2'h0 : tick_ff + 2'h1;
  end
  always_comb begin
    for (int g = 0; g < NQ; g++) begin
      rd_wait_o[g] = slow_i && tick_ff != 2'h3;
      wr_wait_o[g] = slow_i && tick_ff[0];
      rd_data_o[g] = {rd_addr_i[g][15:0], ~rd_addr_i[g][15:0]};
      // Outside the taking cycle the bus shows garbage, not the word
      if (!rd_i[g] || rd_wait_o[g])
        rd_data_o[g] = ~rd_data_o[g];
    end
  end
endmodule : dmact_mem_model

// *** dmact_pkg.sv ***
// Constants, register map and shared types of the DMA channel and
// transfer controller. Assumes one clock and byte addresses on the bus.
package dmact_pkg;

  // ***************
  // Sizes
  // ***************
  localparam int NCH = 64;
  localparam int NQC = 8;
  localparam int NID = 72;
  localparam int NQ = 2;
  localparam int QD = 16;
  localparam int DFD = 16;
  localparam int AHEAD = 4;
  localparam int BURST = 4;
  localparam logic [15:0] WB = 16'h0004;

  // ***************
  // Register byte offsets
  // ***************
  localparam logic [12:0] OFS_LATCH_LO = 13'h0000;
  localparam logic [12:0] OFS_LATCH_HI = 13'h0004;
  localparam logic [12:0] OFS_GATE_LO = 13'h0008;
  localparam logic [12:0] OFS_GATE_HI = 13'h000C;
  localparam logic [12:0] OFS_MSET_LO = 13'h0010;
  localparam logic [12:0] OFS_MSET_HI = 13'h0014;
  localparam logic [12:0] OFS_CHAIN_LO = 13'h0018;
  localparam logic [12:0] OFS_CHAIN_HI = 13'h001C;
  localparam logic [12:0] OFS_QLATCH = 13'h0020;
  localparam logic [12:0] OFS_QMAP_LO = 13'h0024;
  localparam logic [12:0] OFS_QMAP_HI = 13'h0028;
  localparam logic [12:0] OFS_QQMAP = 13'h002C;
  localparam logic [12:0] OFS_QTRIG = 13'h0030;
  localparam logic [12:0] OFS_PEND = 13'h0034;
  localparam logic [12:0] OFS_PEN = 13'h0038;
  localparam logic [12:0] OFS_PCLR = 13'h003C;
  localparam logic [12:0] OFS_FAULT = 13'h0040;
  localparam logic [12:0] OFS_FCLR = 13'h0044;
  localparam logic [12:0] OFS_THR = 13'h0048;
  localparam logic [12:0] OFS_QSTAT = 13'h004C;
  localparam logic [12:0] CTX_BASE = 13'h1000;
  localparam logic [12:0] CTX_END = 13'h1900;

  // ***************
  // Context set layout
  // ***************
  localparam logic [2:0] W_SET = 3'h0;
  localparam logic [2:0] W_SRC = 3'h1;
  localparam logic [2:0] W_CNT = 3'h2;
  localparam logic [2:0] W_DST = 3'h3;
  localparam logic [2:0] W_ASTEP = 3'h4;
  localparam logic [2:0] W_RLD = 3'h5;
  localparam logic [2:0] W_FSTEP = 3'h6;
  localparam logic [2:0] W_FCNT = 3'h7;
  localparam int SYNC_BIT = 2;
  localparam int EARLY_BIT = 11;
  localparam int CODE_LSB = 12;
  localparam int IRQ_BIT = 20;
  localparam int CHAIN_BIT = 22;

  // ***************
  // Fault bits and reset values
  // ***************
  localparam int F_MISS = 0;
  localparam int F_NULL = 1;
  localparam int F_INVAL = 2;
  localparam int F_THR0 = 3;
  localparam int F_W = 5;
  localparam logic [4:0] THR_RST = 5'h10;

  typedef struct packed {
    logic [31:0] src;
    logic [31:0] dst;
    logic [15:0] n_bytes;
    logic [15:0] n_arr;
    logic [15:0] sstep;
    logic [15:0] dstep;
    logic [5:0] code;
    logic irq;
    logic chain;
  } dmact_order_s;

endpackage : dmact_pkg

// *** dmact_top.sv ***
// DMA channel controller with one transfer controller per event queue.
// Assumes event pins are asynchronous and memory ports share CLOCK_I.
`timescale 1ns/1ps

module dmact_xfer
  import dmact_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ord_valid_i,
  input dmact_order_s ord_i,
  output logic ord_ready_o,
  output logic rd_o,
  output logic [31:0] rd_addr_o,
  input wire logic rd_wait_i,
  input wire logic [31:0] rd_data_i,
  output logic wr_o,
  output logic [31:0] wr_addr_o,
  output logic [31:0] wr_data_o,
  input wire logic wr_wait_i,
  output logic comp_o,
  output logic [5:0] comp_code_o,
  output logic comp_irq_o,
  output logic comp_chain_o
);

  typedef struct packed {
    logic [31:0] a;
    logic [31:0] st;
    logic [15:0] b;
    logic [15:0] n;
    logic [15:0] step;
    logic [15:0] len;
  } dmact_walk_s;

  typedef struct packed {
    dmact_walk_s w;
    logic [5:0] code;
    logic irq;
    logic chain;
  } dmact_dent_s;

  typedef struct packed {
    logic pv;
    dmact_order_s p;
    logic sv;
    dmact_walk_s s;
    dmact_dent_s [AHEAD-1:0] d;
    logic [1:0] dwp;
    logic [1:0] drp;
    logic [2:0] dcnt;
    logic [DFD-1:0][31:0] f;
    logic [3:0] fwp;
    logic [3:0] frp;
    logic [4:0] fcnt;
    logic cv;
    logic [5:0] cc;
    logic ci;
    logic ch;
  } dmact_xst_s;

  dmact_xst_s q_ff;
  dmact_xst_s nxt_q;
  dmact_dent_s hd;
  logic [15:0] left;
  logic [15:0] need;
  logic rd_go;
  logic wr_go;
  logic ld;

  // One word per step; the last word of an array may be partial
  function automatic dmact_walk_s walk_step(input dmact_walk_s w);
    dmact_walk_s r;
    r = w;
    if (w.b > WB) begin
      r.b = w.b - WB;
      r.a = w.a + 32'(WB);
    end else if (w.n > 16'h0001) begin
      r.n = w.n - 16'h0001;
      r.st = w.st + {{16{w.step[15]}}, w.step};
      r.a = r.st;
      r.b = w.len;
    end else begin
      r.n = 16'h0000;
      r.b = 16'h0000;
    end
    return r;
  endfunction : walk_step

  function automatic dmact_walk_s walk_load(input logic [31:0] a,
      input dmact_order_s o, input logic [15:0] step);
    dmact_walk_s r;
    r.a = a;
    r.st = a;
    r.b = o.n_bytes;
    r.n = o.n_arr;
    r.step = step;
    r.len = o.n_bytes;
    return r;
  endfunction : walk_load

  always_comb begin
    nxt_q = q_ff;
    nxt_q.cv = 1'b0;
    hd = q_ff.d[q_ff.drp];
    // Widened so a count near the top cannot wrap to zero words left
    left = 16'((17'(hd.w.b) + 17'h00003) >> 2);
    need = (left < 16'(BURST)) ? left : 16'(BURST);
    rd_go = q_ff.sv && (q_ff.fcnt < 5'(DFD));
    wr_go = (q_ff.dcnt != 3'h0) && ({11'h000, q_ff.fcnt} >= need);
    ld = q_ff.pv && !q_ff.sv && (q_ff.dcnt < 3'(AHEAD));
    if (rd_go && !rd_wait_i) begin
      nxt_q.f[q_ff.fwp] = rd_data_i;
      nxt_q.fwp = q_ff.fwp + 4'h1;
      nxt_q.s = walk_step(q_ff.s);
      if (nxt_q.s.n == 16'h0000) begin
        nxt_q.sv = 1'b0;
      end
    end
    if (wr_go && !wr_wait_i) begin
      nxt_q.frp = q_ff.frp + 4'h1;
      nxt_q.d[q_ff.drp].w = walk_step(hd.w);
      if (nxt_q.d[q_ff.drp].w.n == 16'h0000) begin
        nxt_q.drp = q_ff.drp + 2'h1;
        nxt_q.cv = hd.irq | hd.chain;
        nxt_q.cc = hd.code;
        nxt_q.ci = hd.irq;
        nxt_q.ch = hd.chain;
      end
    end
    nxt_q.fcnt = q_ff.fcnt + 5'(rd_go && !rd_wait_i)
      - 5'(wr_go && !wr_wait_i);
    // Program set hands over to source side and next destination slot
    if (ld) begin
      nxt_q.sv = 1'b1;
      nxt_q.pv = 1'b0;
      nxt_q.s = walk_load(q_ff.p.src, q_ff.p, q_ff.p.sstep);
      nxt_q.d[q_ff.dwp].w = walk_load(q_ff.p.dst, q_ff.p, q_ff.p.dstep);
      nxt_q.d[q_ff.dwp].code = q_ff.p.code;
      nxt_q.d[q_ff.dwp].irq = q_ff.p.irq;
      nxt_q.d[q_ff.dwp].chain = q_ff.p.chain;
      nxt_q.dwp = q_ff.dwp + 2'h1;
    end
    nxt_q.dcnt = q_ff.dcnt + 3'(ld)
      - 3'(wr_go && !wr_wait_i && nxt_q.d[q_ff.drp].w.n == 16'h0000);
    ord_ready_o = !q_ff.pv || ld;
    if (ord_valid_i && ord_ready_o) begin
      nxt_q.pv = 1'b1;
      nxt_q.p = ord_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign rd_o = rd_go;
  assign rd_addr_o = q_ff.s.a;
  assign wr_o = wr_go;
  assign wr_addr_o = hd.w.a;
  assign wr_data_o = q_ff.f[q_ff.frp];
  assign comp_o = q_ff.cv;
  assign comp_code_o = q_ff.cc;
  assign comp_irq_o = q_ff.ci;
  assign comp_chain_o = q_ff.ch;

endmodule : dmact_xfer

module dmact_top
  import dmact_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  // Avalon-MM register slave
  input wire logic [12:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // Peripheral events
  input wire logic [NCH-1:0] EVT_I,
  // Source read ports, one per transfer controller
  output logic [NQ-1:0] MRD_READ_O,
  output logic [NQ-1:0][31:0] MRD_ADDR_O,
  input wire logic [NQ-1:0] MRD_WAIT_I,
  input wire logic [NQ-1:0][31:0] MRD_DATA_I,
  // Destination write ports, one per transfer controller
  output logic [NQ-1:0] MWR_WRITE_O,
  output logic [NQ-1:0][31:0] MWR_ADDR_O,
  output logic [NQ-1:0][31:0] MWR_DATA_O,
  input wire logic [NQ-1:0] MWR_WAIT_I,
  // Interrupts
  output logic COMPLETION_IRQ_O,
  output logic FAULT_IRQ_O
);

  typedef struct packed {
    logic [NCH-1:0] s1;
    logic [NCH-1:0] s2;
    logic [NCH-1:0] s3;
    logic [NCH-1:0] latch;
    logic [NCH-1:0] gate;
    logic [NCH-1:0] chl;
    logic [NCH-1:0] qmap;
    logic [NQC-1:0] qlatch;
    logic [NQC-1:0] qqmap;
    logic [NQC-1:0][2:0] qtrig;
    logic [31:0] pend;
    logic [31:0] pen;
    logic [F_W-1:0] fault;
    logic [4:0] thr;
    logic [NQ-1:0][QD-1:0][6:0] qm;
    logic [NQ-1:0][3:0] qwp;
    logic [NQ-1:0][3:0] qrp;
    logic [NQ-1:0][4:0] qcnt;
    logic ack;
    logic [31:0] rdata;
    logic sq;
  } dmact_cc_s;

  dmact_cc_s q_ff;
  dmact_cc_s nxt_q;
  logic [31:0] ctx_mem [NID*8];
  logic [9:0] cidx;
  logic in_ctx;
  logic wr_ok;
  logic ctx_bwr;
  logic [NID-1:0] newe;
  logic [NID-1:0] clr;
  logic [NID-1:0] allp;
  logic [6:0] hid;
  logic [31:0] sw;
  logic [31:0] w_src;
  logic [31:0] w_dst;
  logic [31:0] w_cnt;
  logic [31:0] w_ast;
  logic [31:0] w_fst;
  logic [15:0] w_rld;
  logic [15:0] w_fcnt;
  logic [31:0] u_src;
  logic [31:0] u_dst;
  logic [15:0] u_arr;
  logic [15:0] u_fcnt;
  logic nul;
  logic bad;
  logic try_s;
  logic pop;
  logic go;
  logic early;
  logic sel_v;
  logic sel_q;
  logic [6:0] sel;
  logic [31:0] fs;
  logic [31:0] as;
  dmact_order_s ord;
  logic [NQ-1:0] tc_rdy;
  logic [NQ-1:0] cmp_v;
  logic [NQ-1:0][5:0] cmp_c;
  logic [NQ-1:0] cmp_i;
  logic [NQ-1:0] cmp_ch;

  // ***************
  // Channel controller
  // ***************
  always_comb begin
    nxt_q = q_ff;
    nxt_q.s1 = EVT_I;
    nxt_q.s2 = q_ff.s1;
    nxt_q.s3 = q_ff.s2;
    nxt_q.ack = (AVS_READ_I || AVS_WRITE_I) && !q_ff.ack;
    nxt_q.sq = q_ff.sq + 1'b1;
    // Partial writes are ignored so no register ever holds a torn word
    wr_ok = AVS_WRITE_I && q_ff.ack && (AVS_BYTEENABLE_I == 4'hF);
    in_ctx = (AVS_ADDRESS_I >= CTX_BASE) && (AVS_ADDRESS_I < CTX_END);
    cidx = 10'((AVS_ADDRESS_I - CTX_BASE) >> 2);
    ctx_bwr = wr_ok && in_ctx;
    newe = '0;
    clr = '0;
    newe[NCH-1:0] = q_ff.s2 & ~q_ff.s3 & q_ff.gate;
    for (int i = 0; i < NQC; i++) begin
      if (ctx_bwr && cidx == {7'(NCH + i), q_ff.qtrig[i]}) begin
        newe[NCH+i] = 1'b1;
      end
    end
    // Head of the serviced queue reads its own context set
    hid = q_ff.qm[q_ff.sq][q_ff.qrp[q_ff.sq]];
    sw = ctx_mem[{hid, W_SET}];
    w_src = ctx_mem[{hid, W_SRC}];
    w_dst = ctx_mem[{hid, W_DST}];
    w_cnt = ctx_mem[{hid, W_CNT}];
    w_ast = ctx_mem[{hid, W_ASTEP}];
    w_fst = ctx_mem[{hid, W_FSTEP}];
    w_rld = ctx_mem[{hid, W_RLD}][15:0];
    w_fcnt = ctx_mem[{hid, W_FCNT}][15:0];
    nul = (w_cnt == 32'h0) && (w_fcnt == 16'h0);
    bad = !nul && (w_cnt[15:0] == 16'h0 || w_cnt[31:16] == 16'h0
      || w_fcnt == 16'h0);
    // Bus writes to the table win; submission simply retries next visit
    try_s = (q_ff.qcnt[q_ff.sq] != 5'h0) && !ctx_bwr;
    pop = try_s && (nul || bad || tc_rdy[q_ff.sq]);
    go = try_s && !nul && !bad && tc_rdy[q_ff.sq];
    early = sw[EARLY_BIT];
    ord.src = w_src;
    ord.dst = w_dst;
    ord.n_bytes = w_cnt[15:0];
    ord.n_arr = sw[SYNC_BIT] ? w_cnt[31:16] : 16'h0001;
    ord.sstep = w_ast[15:0];
    ord.dstep = w_ast[31:16];
    ord.code = sw[CODE_LSB +: 6];
    ord.irq = sw[IRQ_BIT] && !early;
    ord.chain = sw[CHAIN_BIT] && !early;
    fs = {{16{w_fst[15]}}, w_fst[15:0]};
    as = {{16{w_ast[15]}}, w_ast[15:0]};
    u_arr = w_cnt[31:16];
    u_fcnt = w_fcnt;
    u_src = w_src + fs;
    u_dst = w_dst + {{16{w_fst[31]}}, w_fst[31:16]};
    if (sw[SYNC_BIT]) begin
      u_fcnt = w_fcnt - 16'h0001;
    end else if (w_cnt[31:16] > 16'h0001) begin
      u_arr = w_cnt[31:16] - 16'h0001;
      u_src = w_src + as;
      u_dst = w_dst + {{16{w_ast[31]}}, w_ast[31:16]};
    end else begin
      u_arr = w_rld;
      u_fcnt = w_fcnt - 16'h0001;
    end
    if (pop) begin
      nxt_q.qrp[q_ff.sq] = q_ff.qrp[q_ff.sq] + 4'h1;
    end
    nxt_q.fault[F_NULL] = q_ff.fault[F_NULL] | (pop && nul);
    nxt_q.fault[F_INVAL] = q_ff.fault[F_INVAL] | (pop && bad);
    // Completion detection: early, then each controller
    nxt_q.pend = q_ff.pend;
    if (go && early && sw[IRQ_BIT]) begin
      nxt_q.pend[sw[CODE_LSB +: 5]] = 1'b1;
    end
    if (go && early && sw[CHAIN_BIT]) begin
      newe[sw[CODE_LSB +: 6]] = 1'b1;
    end
    for (int k = 0; k < NQ; k++) begin
      if (cmp_v[k] && cmp_i[k]) begin
        nxt_q.pend[cmp_c[k][4:0]] = 1'b1;
      end
      if (cmp_v[k] && cmp_ch[k]) begin
        newe[cmp_c[k]] = 1'b1;
      end
    end
    // Arbitration: scan down so the lowest id, DMA before quick, wins
    allp = {q_ff.qlatch, q_ff.latch};
    sel_v = 1'b0;
    sel_q = 1'b0;
    sel = 7'h00;
    for (int i = NID - 1; i >= 0; i--) begin
      if (allp[i]) begin
        if (i < NCH) begin
          if (q_ff.qcnt[q_ff.qmap[i]] != 5'(QD)) begin
            sel_v = 1'b1;
            sel_q = q_ff.qmap[i];
            sel = 7'(i);
          end
        end else if (q_ff.qcnt[q_ff.qqmap[i-NCH]] != 5'(QD)) begin
          sel_v = 1'b1;
          sel_q = q_ff.qqmap[i-NCH];
          sel = 7'(i);
        end
      end
    end
    if (sel_v) begin
      clr[sel] = 1'b1;
      nxt_q.qm[sel_q][q_ff.qwp[sel_q]] = sel;
      nxt_q.qwp[sel_q] = q_ff.qwp[sel_q] + 4'h1;
    end
    for (int j = 0; j < NQ; j++) begin
      nxt_q.qcnt[j] = q_ff.qcnt[j] + 5'(sel_v && sel_q == 1'(j))
        - 5'(pop && q_ff.sq == 1'(j));
      if (q_ff.qcnt[j] > q_ff.thr) begin
        nxt_q.fault[F_THR0+j] = 1'b1;
      end
    end
    // Latch: a new event outranks the clear of the same bit
    nxt_q.fault[F_MISS] = q_ff.fault[F_MISS] | (|(newe & allp & ~clr));
    nxt_q.latch = (q_ff.latch & ~clr[NCH-1:0]) | newe[NCH-1:0];
    nxt_q.qlatch = (q_ff.qlatch & ~clr[NID-1:NCH]) | newe[NID-1:NCH];
    nxt_q.chl = q_ff.chl & ~clr[NCH-1:0];
    for (int k = 0; k < NQ; k++) begin
      if (cmp_v[k] && cmp_ch[k]) begin
        nxt_q.chl[cmp_c[k]] = 1'b1;
      end
    end
    if (go && early && sw[CHAIN_BIT]) begin
      nxt_q.chl[sw[CODE_LSB +: 6]] = 1'b1;
    end
    // ***************
    // Register writes
    // ***************
    if (wr_ok) begin
      unique case (AVS_ADDRESS_I)
        OFS_GATE_LO: nxt_q.gate[31:0] = AVS_WRITEDATA_I;
        OFS_GATE_HI: nxt_q.gate[63:32] = AVS_WRITEDATA_I;
        OFS_MSET_LO: nxt_q.latch[31:0] = nxt_q.latch[31:0] | AVS_WRITEDATA_I;
        OFS_MSET_HI: nxt_q.latch[63:32] = nxt_q.latch[63:32] | AVS_WRITEDATA_I;
        OFS_QMAP_LO: nxt_q.qmap[31:0] = AVS_WRITEDATA_I;
        OFS_QMAP_HI: nxt_q.qmap[63:32] = AVS_WRITEDATA_I;
        OFS_QQMAP: nxt_q.qqmap = AVS_WRITEDATA_I[NQC-1:0];
        OFS_QTRIG: nxt_q.qtrig = AVS_WRITEDATA_I[3*NQC-1:0];
        OFS_PEN: nxt_q.pen = AVS_WRITEDATA_I;
        OFS_PCLR: nxt_q.pend = nxt_q.pend & ~(AVS_WRITEDATA_I & ~q_ff.pend
          | AVS_WRITEDATA_I) | (nxt_q.pend & ~q_ff.pend);
        OFS_FCLR: nxt_q.fault = nxt_q.fault & ~AVS_WRITEDATA_I[F_W-1:0]
          | (nxt_q.fault & ~q_ff.fault);
        OFS_THR: nxt_q.thr = AVS_WRITEDATA_I[4:0];
        default: ;
      endcase
    end
    if (wr_ok && AVS_ADDRESS_I == OFS_MSET_LO) begin
      nxt_q.fault[F_MISS] = nxt_q.fault[F_MISS]
        | (|(AVS_WRITEDATA_I & q_ff.latch[31:0] & ~clr[31:0]));
    end
    if (wr_ok && AVS_ADDRESS_I == OFS_MSET_HI) begin
      nxt_q.fault[F_MISS] = nxt_q.fault[F_MISS]
        | (|(AVS_WRITEDATA_I & q_ff.latch[63:32] & ~clr[63:32]));
    end
    // Read data is captured in the wait cycle, stands at the release edge
    nxt_q.rdata = 32'h0;
    if (in_ctx) begin
      nxt_q.rdata = ctx_mem[cidx];
    end else begin
      unique case (AVS_ADDRESS_I)
        OFS_LATCH_LO: nxt_q.rdata = q_ff.latch[31:0];
        OFS_LATCH_HI: nxt_q.rdata = q_ff.latch[63:32];
        OFS_GATE_LO: nxt_q.rdata = q_ff.gate[31:0];
        OFS_GATE_HI: nxt_q.rdata = q_ff.gate[63:32];
        OFS_CHAIN_LO: nxt_q.rdata = q_ff.chl[31:0];
        OFS_CHAIN_HI: nxt_q.rdata = q_ff.chl[63:32];
        OFS_QLATCH: nxt_q.rdata = {24'h0, q_ff.qlatch};
        OFS_QMAP_LO: nxt_q.rdata = q_ff.qmap[31:0];
        OFS_QMAP_HI: nxt_q.rdata = q_ff.qmap[63:32];
        OFS_QQMAP: nxt_q.rdata = {24'h0, q_ff.qqmap};
        OFS_QTRIG: nxt_q.rdata = {8'h0, q_ff.qtrig};
        OFS_PEND: nxt_q.rdata = q_ff.pend;
        OFS_PEN: nxt_q.rdata = q_ff.pen;
        OFS_FAULT: nxt_q.rdata = {27'h0, q_ff.fault};
        OFS_THR: nxt_q.rdata = {27'h0, q_ff.thr};
        OFS_QSTAT: nxt_q.rdata = {22'h0, q_ff.qcnt};
        default: nxt_q.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      q_ff <= '0;
      q_ff.thr <= THR_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Context table: bus writes first, then the submitted set's update
  always_ff @(posedge CLOCK_I) begin
    if (ctx_bwr) begin
      ctx_mem[cidx] <= AVS_WRITEDATA_I;
    end else if (go) begin
      ctx_mem[{hid, W_SRC}] <= u_src;
      ctx_mem[{hid, W_DST}] <= u_dst;
      ctx_mem[{hid, W_CNT}] <= {u_arr, w_cnt[15:0]};
      ctx_mem[{hid, W_FCNT}] <= {16'h0, u_fcnt};
    end
  end

  // ***************
  // Transfer controllers, queue g feeds controller g
  // ***************
  for (genvar g = 0; g < NQ; g++) begin : g_tc
    dmact_xfer u_xfer (
      .clk_i(CLOCK_I),
      .rst_i(SYS_RST_I),
      .ord_valid_i(go && q_ff.sq == 1'(g)),
      .ord_i(ord),
      .ord_ready_o(tc_rdy[g]),
      .rd_o(MRD_READ_O[g]),
      .rd_addr_o(MRD_ADDR_O[g]),
      .rd_wait_i(MRD_WAIT_I[g]),
      .rd_data_i(MRD_DATA_I[g]),
      .wr_o(MWR_WRITE_O[g]),
      .wr_addr_o(MWR_ADDR_O[g]),
      .wr_data_o(MWR_DATA_O[g]),
      .wr_wait_i(MWR_WAIT_I[g]),
      .comp_o(cmp_v[g]),
      .comp_code_o(cmp_c[g]),
      .comp_irq_o(cmp_i[g]),
      .comp_chain_o(cmp_ch[g])
    );
  end

  assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !q_ff.ack;
  assign AVS_READDATA_O = q_ff.rdata;
  assign COMPLETION_IRQ_O = |(q_ff.pend & q_ff.pen);
  assign FAULT_IRQ_O = |q_ff.fault;

endmodule : dmact_top

// *** dmact_top_props.sv ***
// Checker of dmact_top: bus wait state, data FIFO fill, irq reset.
// Sees only the top module's ports; the bind follows the module.
`timescale 1ns/1ps
module dmact_top_props
  import dmact_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  // Register bus
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic AVS_WAITREQUEST_O,
  // Memory ports
  input wire logic [NQ-1:0] MRD_READ_O,
  input wire logic [NQ-1:0][31:0] MRD_ADDR_O,
  input wire logic [NQ-1:0] MRD_WAIT_I,
  input wire logic [NQ-1:0] MWR_WRITE_O,
  input wire logic [NQ-1:0][31:0] MWR_DATA_O,
  input wire logic [NQ-1:0] MWR_WAIT_I,
  // Interrupts
  input wire logic COMPLETION_IRQ_O,
  input wire logic FAULT_IRQ_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);
  // ****
  // Words held in data FIFO 0, counted from the port handshakes
  // ****
  logic [5:0] fill_ff;
  logic [5:0] nxt_fill;
  always_comb begin
    nxt_fill = fill_ff + 6'(MRD_READ_O[0] && !MRD_WAIT_I[0])
      - 6'(MWR_WRITE_O[0] && !MWR_WAIT_I[0]);
  end
  always_ff @(posedge CLOCK_I) begin
    fill_ff <= SYS_RST_I ? 6'h00 : nxt_fill;
  end
  a_fifo_room: assert property (fill_ff <= 6'h10)
    else $error("data FIFO 0 holds more than 16 words");
  a_wr_has_data: assert property (MWR_WRITE_O[0] |-> fill_ff != 6'h00)
    else $error("write issued with an empty data FIFO");
  a_rd_held: assert property (MRD_READ_O[0] && MRD_WAIT_I[0] |=>
      MRD_READ_O[0] && $stable(MRD_ADDR_O[0]))
    else $error("read 0 changed while held");
  a_rd_held_one: assert property (MRD_READ_O[1] && MRD_WAIT_I[1] |=>
      MRD_READ_O[1] && $stable(MRD_ADDR_O[1]))
    else $error("read 1 changed while held");
  a_wr_held: assert property (MWR_WRITE_O[1] && MWR_WAIT_I[1] |=>
      MWR_WRITE_O[1] && $stable(MWR_DATA_O[1]))
    else $error("write 1 changed while held");
  a_wait_first: assert property ($rose(AVS_READ_I || AVS_WRITE_I)
      |-> AVS_WAITREQUEST_O) else $error("no wait in first bus cycle");
  a_wait_once: assert property (AVS_WAITREQUEST_O
      |=> !AVS_WAITREQUEST_O) else $error("more than one wait cycle");
  a_irq_reset: assert property ($fell(SYS_RST_I)
      |-> !FAULT_IRQ_O && !COMPLETION_IRQ_O)
    else $error("interrupt high after reset");
endmodule : dmact_top_props
bind dmact_top dmact_top_props u_props (.CLOCK_I, .SYS_RST_I,
  .AVS_READ_I, .AVS_WRITE_I, .AVS_WAITREQUEST_O, .MRD_READ_O,
  .MRD_ADDR_O, .MRD_WAIT_I, .MWR_WRITE_O, .MWR_DATA_O, .MWR_WAIT_I,
  .COMPLETION_IRQ_O, .FAULT_IRQ_O);

// *** dmact_top_tb_top.sv ***
// Bench of dmact_top: table of transfers, then irq and null cases.
// Assumes dmact_mem_model answers both memory ports.
`timescale 1ns/1ps
module dmact_top_tb_top
  import dmact_pkg::*;
;
  typedef struct packed {
    logic [6:0] ch;
    logic [1:0] trig;
    logic [31:0] set;
    logic [15:0] nb, na, ai;
  } dmact_row_s;
  // Trig 0 manual set, 1 pin edge, 2 quick trigger word
  localparam dmact_row_s ROWS [5] = '{
    '{7'h00, 2'h0, 32'h0000_0004, 16'h0008, 16'h0002, 16'h0000},
    '{7'h01, 2'h0, 32'h0010_3000, 16'h0004, 16'h0003, 16'h0000},
    '{7'h01, 2'h0, 32'h0010_3000, 16'h0004, 16'h0003, 16'h0001},
    '{7'h03, 2'h1, 32'h0040_1004, 16'h0006, 16'h0001, 16'h0000},
    '{7'h40, 2'h2, 32'h0010_9804, 16'h0010, 16'h0002, 16'h0000}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic slow = 1'b0;
  logic [12:0] addr = 13'h0000;
  logic [31:0] wdat = 32'h0;
  logic [NCH-1:0] evt = '0;
  logic [31:0] rdat;
  logic wrq, cirq, firq;
  logic [NQ-1:0] mrd, mrw, mww, mwwt;
  logic [NQ-1:0][31:0] mra, mrdat, mwa, mwd;
  logic [63:0] wq [NQ][$];
  int n_errors = 0;
  int n_checks = 0;
  initial forever #2.5 clk = ~clk;
  dmact_top DUT (.CLOCK_I(clk), .SYS_RST_I(rst), .AVS_ADDRESS_I(addr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat),
    .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wrq), .EVT_I(evt), .MRD_READ_O(mrd),
    .MRD_ADDR_O(mra), .MRD_WAIT_I(mrw), .MRD_DATA_I(mrdat),
    .MWR_WRITE_O(mww), .MWR_ADDR_O(mwa), .MWR_DATA_O(mwd),
    .MWR_WAIT_I(mwwt), .COMPLETION_IRQ_O(cirq), .FAULT_IRQ_O(firq));
  dmact_mem_model u_mem (.clk_i(clk), .rst_i(rst), .slow_i(slow),
    .rd_i(mrd), .rd_addr_i(mra), .rd_wait_o(mrw), .rd_data_o(mrdat),
    .wr_wait_o(mwwt));
  always @(posedge clk)
    for (int g = 0; g < NQ; g++)
      if (mww[g] && !mwwt[g]) wq[g].push_back({mwa[g], mwd[g]});
  function automatic logic [31:0] pat(input logic [31:0] x);
    return {x[15:0], ~x[15:0]};
  endfunction : pat
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [12:0] a,
      input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdat <= d;
    do @(posedge clk); while (wrq);
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic prog(input int c, input logic [31:0] s,
      input logic [15:0] nb, na, fc);
    logic [31:0] w [8];
    logic [31:0] x;
    w = '{s, 32'h0010_0000 + 32'(c * 256), {na, nb},
      32'h0020_0000 + 32'(c * 256), 32'h0080_0040, {16'h0, na},
      32'h0, {16'h0, fc}};
    for (int i = 0; i < 8; i++)
      bus(1'b1, CTX_BASE + 13'(c * 32 + i * 4), w[i], x);
  endtask : prog
  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  // Whole run needs a few hundred cycles; allow 60000
  initial begin
    #300000;
    n_errors++;
    close_out();
  end
  initial begin
    dmact_row_s r;
    logic [63:0] w;
    logic [31:0] d;
    int q, n, wpa, a;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, OFS_THR, 32'h0, d);
    chk("threshold", d, 32'h10);
    bus(1'b0, 13'h0800, 32'h0, d);
    chk("unmapped", d, 32'h0);
    bus(1'b1, OFS_QMAP_LO, 32'hAAAA_AAAA, d);
    bus(1'b1, OFS_QTRIG, 32'h7, d);
    bus(1'b1, OFS_GATE_LO, 32'h8, d);
    foreach (ROWS[i]) begin
      r = ROWS[i];
      slow <= (i != 0);
      q = r.ch[6] ? 0 : int'(r.ch[0]);
      if (r.ai == 16'h0) prog(r.ch, r.set, r.nb, r.na, 16'h1);
      if (r.trig == 2'h0) bus(1'b1, OFS_MSET_LO, 32'h1 << r.ch, d);
      if (r.trig == 2'h1) begin
        evt[r.ch[5:0]] <= 1'b1;
        repeat (4) @(posedge clk);
        evt <= '0;
      end
      wpa = (r.nb + 3) / 4;
      n = r.set[SYNC_BIT] ? wpa * r.na : wpa;
      for (int t = 0; t < 3000 && wq[q].size() < n; t++) @(posedge clk);
      chk("writes", 32'(wq[q].size()), 32'(n));
      for (int k = 0; k < n; k++) begin
        a = r.set[SYNC_BIT] ? k / wpa : r.ai;
        w = wq[q].pop_front();
        d = 32'(r.ch * 256 + 4 * (k % wpa));
        chk("addr", w[63:32], 32'h0020_0000 + d + 32'(a * 128));
        chk("data", w[31:0], pat(32'h0010_0000 + d + 32'(a * 64)));
      end
    end
    repeat (20) @(posedge clk);
    // Row 3 chains into channel 1, which then moves its third array
    chk("chain writes", 32'(wq[1].size()), 32'h1);
    w = wq[1].pop_front();
    chk("chain addr", w[63:32], 32'h0020_0200);
    chk("chain data", w[31:0], pat(32'h0010_0180));
    bus(1'b0, OFS_PEND, 32'h0, d);
    chk("pending", d, 32'h208);
    chk("irq masked", {31'h0, cirq}, 32'h0);
    bus(1'b1, OFS_PEN, 32'h208, d);
    @(posedge clk);
    chk("irq on", {31'h0, cirq}, 32'h1);
    bus(1'b1, OFS_PCLR, 32'h208, d);
    @(posedge clk);
    chk("irq off", {31'h0, cirq}, 32'h0);
    prog(4, 32'h0, 16'h0, 16'h0, 16'h0);
    bus(1'b1, OFS_MSET_LO, 32'h10, d);
    repeat (20) @(posedge clk);
    bus(1'b0, OFS_FAULT, 32'h0, d);
    chk("null fault", d, 32'h1 << F_NULL);
    chk("fault irq", {31'h0, firq}, 32'h1);
    bus(1'b1, OFS_FCLR, 32'hFFFF_FFFF, d);
    bus(1'b0, OFS_FAULT, 32'h0, d);
    chk("fault clear", d, 32'h0);
    close_out();
  end
endmodule : dmact_top_tb_top
